// ### rtl/pin_mux.sv
// two configurable pins: pad control, input role routing, output sourcing
// pad inputs pass a two-flop synchronizer; assumes role sources are synchronous-safe levels from the chip
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module pin_mux #(
    parameter int unsigned DEB_NORMAL_CYCLES = pin_mux_pkg::DEB_NORMAL_CYC,
    parameter int unsigned DEB_LONG_CYCLES   = pin_mux_pkg::DEB_LONG_CYC
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic [31:0]              awaddr_i,
    input  wire logic                     awvalid_i,
    output logic                          awready_o,
    input  wire logic [31:0]              wdata_i,
    input  wire logic [3:0]               wstrb_i,
    input  wire logic                     wvalid_i,
    output logic                          wready_o,
    output logic [1:0]                    bresp_o,
    output logic                          bvalid_o,
    input  wire logic                     bready_i,
    input  wire logic [31:0]              araddr_i,
    input  wire logic                     arvalid_i,
    output logic                          arready_o,
    output logic [31:0]                   rdata_o,
    output logic [1:0]                    rresp_o,
    output logic                          rvalid_o,
    input  wire logic                     rready_i,
    input  wire logic [1:0]               pad_in_i,
    output pin_mux_pkg::pad_t [1:0]       pad_o,
    input  wire logic [15:0]              out_src_i,
    output logic [15:0]                   role_o,
    output logic [1:0]                    edge_event_o
);
    localparam int unsigned CW = $clog2(DEB_LONG_CYCLES + 1);

    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        logic [2:0] s;
        s = pin_mux_pkg::SEL_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[31:2])
                pin_mux_pkg::IDX_PIN_TWO:   s = pin_mux_pkg::SEL_PIN_TWO;
                pin_mux_pkg::IDX_PIN_THREE: s = pin_mux_pkg::SEL_PIN_THREE;
                pin_mux_pkg::IDX_OUT_LEVEL: s = pin_mux_pkg::SEL_OUT_LEVEL;
                pin_mux_pkg::IDX_STATUS:    s = pin_mux_pkg::SEL_STATUS;
                default:                    s = pin_mux_pkg::SEL_NONE;
            endcase
        end
        return s;
    endfunction : reg_sel

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  strb);
        logic [15:0] m;
        m = old;
        if (strb[0]) begin
            m[7:0] = d[7:0];
        end
        if (strb[1]) begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction : merge16

    // long-debounce input codes: 0, 4, 14, 15
    function automatic logic is_long(input logic [3:0] fn);
        return (fn == 4'h0) || (fn == 4'h4) || (fn == 4'hE) || (fn == 4'hF);
    endfunction : is_long

    logic [15:0] ctrl_r    [2];
    logic [15:0] ctrl_nxt  [2];
    logic [1:0]  out_lvl_r;
    logic [1:0]  out_lvl_nxt;
    logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [31:0] aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        awready_r, awready_nxt, wready_r, wready_nxt;
    logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [3:0]  deb_lvl;
    logic [15:0] contrib [2];
    logic [15:0] role_r, role_nxt;

    assign awready_o = awready_r;
    assign wready_o  = wready_r;
    assign bvalid_o  = bvalid_r;
    assign bresp_o   = bresp_r;
    assign arready_o = arready_r;
    assign rvalid_o  = rvalid_r;
    assign rresp_o   = rresp_r;
    assign rdata_o   = rdata_r;
    assign role_o    = role_r;

    // address and data taken in either order; response once both are held
    always_comb begin
        logic [2:0] ws;
        logic [2:0] rs;
        ws = reg_sel(aw_addr_r);
        rs = reg_sel(araddr_i);
        ctrl_nxt    = ctrl_r;
        out_lvl_nxt = out_lvl_r;
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt  = w_have_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (awvalid_i && awready_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = awaddr_i;
        end
        if (wvalid_i && wready_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = wdata_i;
            w_strb_nxt = wstrb_i;
        end
        if (bvalid_r && bready_i) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_have_r && w_have_r && !bvalid_r) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = pin_mux_pkg::RESP_OKAY;
            case (ws)
                pin_mux_pkg::SEL_PIN_TWO, pin_mux_pkg::SEL_PIN_THREE: begin
                    // reserved bits stay zero
                    ctrl_nxt[ws[0]] = merge16(ctrl_r[ws[0]], w_data_r, w_strb_r)
                                      & pin_mux_pkg::CTRL_WMASK;
                end
                pin_mux_pkg::SEL_OUT_LEVEL: begin
                    if (w_strb_r[0]) begin
                        out_lvl_nxt = w_data_r[1:0];
                    end
                end
                pin_mux_pkg::SEL_STATUS: begin
                    // read-only, write ignored
                end
                default: begin
                    bresp_nxt = pin_mux_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && rready_i) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid_i && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = pin_mux_pkg::RESP_OKAY;
            case (rs)
                pin_mux_pkg::SEL_PIN_TWO:   rdata_nxt = {16'h0000, ctrl_r[0]};
                pin_mux_pkg::SEL_PIN_THREE: rdata_nxt = {16'h0000, ctrl_r[1]};
                pin_mux_pkg::SEL_OUT_LEVEL: rdata_nxt = {30'h0000_0000, out_lvl_r};
                pin_mux_pkg::SEL_STATUS:    rdata_nxt = {28'h000_0000, deb_lvl};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = pin_mux_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt  = !w_have_nxt && !bvalid_nxt;
        arready_nxt = !rvalid_nxt;
        role_nxt    = contrib[0] | contrib[1];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r[0] <= pin_mux_pkg::CTRL_RESET;
            ctrl_r[1] <= pin_mux_pkg::CTRL_RESET;
            out_lvl_r <= pin_mux_pkg::OUT_LEVEL_RESET;
            aw_have_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            w_have_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= 2'h0;
            rdata_r   <= 32'h0000_0000;
            role_r    <= 16'h0000;
        end else begin
            ctrl_r    <= ctrl_nxt;
            out_lvl_r <= out_lvl_nxt;
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r  <= w_have_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            role_r    <= role_nxt;
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_pin
        pin_mux_pkg::pin_cfg_t cfg;
        logic              s1_r, s2_r;
        logic [CW-1:0]     cnt_r [2];
        logic [CW-1:0]     cnt_nxt [2];
        logic [1:0]        lvl_r, lvl_nxt;
        logic              prev_r, prev_nxt, evt_r, evt_nxt;
        logic              sense, src, drv;
        pin_mux_pkg::pad_t pad_r, pad_nxt;

        assign cfg             = ctrl_r[p];
        assign pad_o[p]        = pad_r;
        assign edge_event_o[p] = evt_r;
        assign deb_lvl[2*p+1:2*p] = lvl_r;

        always_comb begin
            for (int k = 0; k < 2; k++) begin
                cnt_nxt[k] = '0;
                lvl_nxt[k] = lvl_r[k];
                // filter: level must hold for the full window
                if (s2_r != lvl_r[k]) begin
                    if (cnt_r[k] == CW'((k == 0 ? DEB_NORMAL_CYCLES
                                                : DEB_LONG_CYCLES) - 1)) begin
                        lvl_nxt[k] = s2_r;
                    end else begin
                        cnt_nxt[k] = cnt_r[k] + CW'(1);
                    end
                end
            end
            sense = is_long(cfg.function_code) ? lvl_r[1] : lvl_r[0];
            sense = cfg.polarity ? sense : !sense;
            prev_nxt = sense;
            evt_nxt = cfg.enable && cfg.direction &&
                      (cfg.irq_edge_mode ? (sense != prev_r) : (sense && !prev_r));
            contrib[p] = (cfg.enable && cfg.direction)
                         ? (16'h0001 << cfg.function_code) & {16{sense}} : 16'h0000;
            if (cfg.function_code == pin_mux_pkg::FN_GPIO) begin
                src = out_lvl_r[p];
            end else if (cfg.function_code >= pin_mux_pkg::FN_RSVD_LO &&
                         cfg.function_code <= pin_mux_pkg::FN_RSVD_HI) begin
                src = 1'b0;
            end else begin
                src = out_src_i[cfg.function_code];
            end
            drv = cfg.polarity ? src : !src;
            pad_nxt.supply_select = cfg.supply_select;
            // reserved pull code gives no pull
            pad_nxt.pull_up   = (cfg.pull == pin_mux_pkg::PULL_UP);
            pad_nxt.pull_down = (cfg.pull == pin_mux_pkg::PULL_DOWN);
            pad_nxt.out = 1'b0;
            pad_nxt.oe  = 1'b0;
            if (cfg.enable && !cfg.direction) begin
                if (cfg.open_drain) begin
                    pad_nxt.oe = !drv;
                end else begin
                    pad_nxt.oe  = 1'b1;
                    pad_nxt.out = drv;
                end
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1_r     <= 1'b0;
                s2_r     <= 1'b0;
                cnt_r[0] <= '0;
                cnt_r[1] <= '0;
                lvl_r    <= 2'h0;
                prev_r   <= 1'b0;
                evt_r    <= 1'b0;
                pad_r    <= '0;
            end else begin
                s1_r     <= pad_in_i[p];
                s2_r     <= s1_r;
                cnt_r    <= cnt_nxt;
                lvl_r    <= lvl_nxt;
                prev_r   <= prev_nxt;
                evt_r    <= evt_nxt;
                pad_r    <= pad_nxt;
            end
        end
    end
endmodule : pin_mux

// ### rtl/pin_mux_pkg.sv
// constants and types for the two-pin function multiplexer
// assumes a 100 MHz system clock and AXI4-Lite register access
package pin_mux_pkg;
    localparam int unsigned CLK_MHZ         = 100;
    // debounce windows, microseconds
    localparam int unsigned DEB_NORMAL_US   = 10;
    localparam int unsigned DEB_LONG_US     = 1000;
    localparam int unsigned DEB_NORMAL_CYC  = DEB_NORMAL_US * CLK_MHZ;
    localparam int unsigned DEB_LONG_CYC    = DEB_LONG_US * CLK_MHZ;

    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_PIN_TWO     = 30'h0000_4039;
    localparam logic [29:0] IDX_PIN_THREE   = 30'h0000_403A;
    localparam logic [29:0] IDX_OUT_LEVEL   = 30'h0000_4040;
    localparam logic [29:0] IDX_STATUS      = 30'h0000_4041;

    localparam logic [2:0]  SEL_PIN_TWO     = 3'h0;
    localparam logic [2:0]  SEL_PIN_THREE   = 3'h1;
    localparam logic [2:0]  SEL_OUT_LEVEL   = 3'h2;
    localparam logic [2:0]  SEL_STATUS      = 3'h3;
    localparam logic [2:0]  SEL_NONE        = 3'h4;

    localparam logic [15:0] CTRL_RESET      = 16'hA400;
    localparam logic [15:0] CTRL_WMASK      = 16'hFE8F;
    localparam logic [1:0]  OUT_LEVEL_RESET = 2'h0;

    localparam logic [1:0]  PULL_NONE       = 2'h0;
    localparam logic [1:0]  PULL_DOWN       = 2'h1;
    localparam logic [1:0]  PULL_UP         = 2'h2;

    localparam logic [3:0]  FN_GPIO         = 4'h0;
    localparam logic [3:0]  FN_RSVD_LO      = 4'h5;
    localparam logic [3:0]  FN_RSVD_HI      = 4'h7;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // control register layout, bit 15 first
    typedef struct packed {
        logic       direction;
        logic [1:0] pull;
        logic       irq_edge_mode;
        logic       supply_select;
        logic       polarity;
        logic       open_drain;
        logic       rsvd8;
        logic       enable;
        logic [2:0] rsvd6_4;
        logic [3:0] function_code;
    } pin_cfg_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_down;
        logic supply_select;
    } pad_t;
endpackage : pin_mux_pkg

// ### tb/multi_function_pin_control_bench.sv
// bench for the two-pin multiplexer: bus tasks, scoreboard, pin scenarios
// assumes pin_mux, pad_partner and the bound checker are compiled first
`timescale 1ns/10ps
module multi_function_pin_control_bench;
    localparam int unsigned DN = 4;
    localparam int unsigned DL = 16;
    logic                    clk_i = 1'h0;
    logic                    rst_i = 1'h1;
    logic [31:0]             awaddr_i = 32'h0, wdata_i = 32'h0, araddr_i = 32'h0, rdata_o;
    logic [3:0]              wstrb_i = 4'hF;
    logic                    awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0;
    logic                    arvalid_i = 1'h0, rready_i = 1'h0;
    logic                    awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic [1:0]              bresp_o, rresp_o, edge_event_o, pad_in_i;
    logic [1:0]              drv_en = 2'h0, drv_lvl = 2'h0;
    logic [15:0]             out_src_i = 16'h0, role_o, src;
    pin_mux_pkg::pad_t [1:0] pad_o;
    integer                  seed = 32'hD7A3;
    int                      num_errors = 0, n_compared = 0, b = 0;
    int                      ev_cnt[2] = '{0, 0};
    logic [33:0]             rq[$];
    logic [1:0]              bq[$];
    logic [15:0]             ocfg[6] = '{16'h0480, 16'h0080, 16'h0680, 16'h0280, 16'h0400, 16'h8480};
    logic [1:0]              oexp[6] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
    logic [15:0]             ecfg[4] = '{16'h8481, 16'h8081, 16'h9481, 16'h9401};
    int                      erise[4] = '{1, 0, 1, 0};
    int                      eall[4] = '{1, 1, 2, 0};

    pin_mux #(.DEB_NORMAL_CYCLES(DN), .DEB_LONG_CYCLES(DL)) dut (.*);
    pad_partner far (.clk_i(clk_i), .pad_i(pad_o), .drv_en_i(drv_en), .drv_lvl_i(drv_lvl),
                     .level_o(pad_in_i));

    initial forever #5 clk_i = ~clk_i;

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic tmo(input int n);
        if (n >= 100) begin
            num_errors++;
            $display("unexpected handshake: expected answer seen none");
            give_verdict();
        end
    endtask : tmo

    task automatic wr(input logic [29:0] ix, input logic [15:0] v, input logic [1:0] er);
        int n;
        n = 0;
        bq.push_back(er);
        awaddr_i  <= {ix, 2'h0};
        wdata_i   <= {16'($random(seed)), v};
        wstrb_i   <= {2'($random(seed)), 2'h3};
        awvalid_i <= 1'h1;
        wvalid_i  <= 1'h1;
        bready_i  <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
            if (awready_o) awvalid_i <= 1'h0;
            if (wready_o) wvalid_i <= 1'h0;
        end while (!bvalid_o && n < 100);
        bready_i <= 1'h0;
        @(posedge clk_i);
        tmo(n);
    endtask : wr

    task automatic rd(input logic [29:0] ix, input logic [33:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        araddr_i  <= {ix, 2'h0};
        arvalid_i <= 1'h1;
        rready_i  <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
            if (arready_o) arvalid_i <= 1'h0;
        end while (!rvalid_o && n < 100);
        rready_i <= 1'h0;
        @(posedge clk_i);
        tmo(n);
    endtask : rd

    task automatic cfg(input int p, input logic [15:0] v);
        wr(p ? pin_mux_pkg::IDX_PIN_THREE : pin_mux_pkg::IDX_PIN_TWO, v, 2'h0);
        repeat (2) @(posedge clk_i);
    endtask : cfg

    // scoreboard side: answers are matched in issue order
    always @(posedge clk_i) begin
        if (bvalid_o && bready_i) chk("bresp", 34'(bq.pop_front()), 34'(bresp_o));
        if (rvalid_o && rready_i) chk("rdata", rq.pop_front(), {rresp_o, rdata_o});
        foreach (ev_cnt[i]) ev_cnt[i] += int'(edge_event_o[i]);
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(pin_mux_pkg::IDX_PIN_TWO, 34'hA400);
        rd(pin_mux_pkg::IDX_PIN_THREE, 34'hA400);
        chk("pad", 34'(pad_o), 34'h042);
        rd(30'h0000_4050, {pin_mux_pkg::RESP_SLVERR, 32'h0});
        wr(30'h0000_4050, 16'hFFFF, pin_mux_pkg::RESP_SLVERR);
        for (int p = 0; p < 4; p++) begin
            cfg(0, 16'h8400 | 16'(p << 13));
            chk("pull", 34'({pad_o[0].pull_up, pad_o[0].pull_down}), 34'({p == 2, p == 1}));
        end
        cfg(0, 16'hAC00);
        cfg(1, 16'hAC00);
        chk("supply", 34'({pad_o[1].supply_select, pad_o[0].supply_select}), 34'h3);
        cfg(0, 16'hA400);
        chk("supply", 34'({pad_o[1].supply_select, pad_o[0].supply_select}), 34'h2);
        wr(pin_mux_pkg::IDX_OUT_LEVEL, 16'h0003, 2'h0);
        rd(pin_mux_pkg::IDX_OUT_LEVEL, 34'h3);
        wr(pin_mux_pkg::IDX_STATUS, 16'hFFFF, pin_mux_pkg::RESP_OKAY);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 6; k++) begin
                cfg(p, ocfg[k]);
                chk("drive", 34'({pad_o[p].out & pad_o[p].oe, pad_o[p].oe}), 34'(oexp[k]));
            end
        end
        wr(pin_mux_pkg::IDX_OUT_LEVEL, 16'h0001, 2'h0);
        cfg(1, 16'h0480);
        chk("level", 34'({pad_o[1].out, pad_o[1].oe}), 34'h1);
        for (int c = 1; c < 16; c++) begin
            repeat (4) begin
                src = 16'($random(seed));
                out_src_i <= src;
                cfg(0, 16'h0480 | 16'(c));
                chk("source", 34'(pad_o[0].out), 34'((c inside {[5:7]}) ? 1'h0 : src[c]));
            end
        end
        for (int p = 0; p < 2; p++) begin
            // settle both filters low; random output history may leave them high
            cfg(p, 16'h8480);
            drv_en[p]  <= 1'h1;
            drv_lvl[p] <= 1'h0;
            repeat (DL + 8) @(posedge clk_i);
            for (int c = 0; c < 16; c++) begin
                cfg(p, 16'h8480 | 16'(c));
                drv_en[p]  <= 1'h1;
                drv_lvl[p] <= 1'h1;
                repeat (DN + 7) @(posedge clk_i);
                chk("role", 34'(role_o), (c inside {0, 4, 14, 15}) ? 34'h0 : 34'h1 << c);
                repeat (DL) @(posedge clk_i);
                chk("role", 34'(role_o), 34'h1 << c);
                rd(pin_mux_pkg::IDX_STATUS, p ? 34'hC : 34'h3);
                drv_lvl[p] <= 1'h0;
                repeat (DL + 8) @(posedge clk_i);
                chk("role", 34'(role_o), 34'h0);
            end
            for (int k = 0; k < 4; k++) begin
                cfg(p, ecfg[k]);
                repeat (DL) @(posedge clk_i);
                chk("role", 34'(role_o), (k == 1) ? 34'h2 : 34'h0);
                b = ev_cnt[p];
                drv_lvl[p] <= 1'h1;
                repeat (DL) @(posedge clk_i);
                chk("rise", 34'(ev_cnt[p] - b), 34'(erise[k]));
                drv_lvl[p] <= 1'h0;
                repeat (DL) @(posedge clk_i);
                chk("both", 34'(ev_cnt[p] - b), 34'(eall[k]));
            end
        end
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(pin_mux_pkg::IDX_PIN_TWO, 34'hA400);
        chk("pad", 34'(pad_o), 34'h042);
        give_verdict();
    end
endmodule : multi_function_pin_control_bench

// ### tb/pad_partner.sv
// far side of the two pins: external driver, pull resistors, floating wire
// assumes pad controls from pin_mux and drive requests from the bench
`timescale 1ns/10ps
module pad_partner (
    input  wire logic                    clk_i,
    input  wire pin_mux_pkg::pad_t [1:0] pad_i,
    input  wire logic [1:0]              drv_en_i,
    input  wire logic [1:0]              drv_lvl_i,
    output logic [1:0]                   level_o
);
    logic [1:0] last_r = 2'h0;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            level_o[i] = pad_i[i].oe ? pad_i[i].out : drv_en_i[i] ? drv_lvl_i[i] :
                pad_i[i].pull_up ? 1'h1 : pad_i[i].pull_down ? 1'h0 : ~last_r[i];
        end
    end
    // undriven wire toggles so no level is trusted
    always_ff @(posedge clk_i) last_r <= level_o;
endmodule : pad_partner

// ### tb/pin_mux_assertions.sv
// checker for the two-pin multiplexer: bus timing, pad and event relations
// assumes it is bound into pin_mux and sees only that module's ports
`timescale 1ns/10ps
module pin_mux_assertions #(
    parameter int unsigned DEB_NORMAL_CYCLES = 4,
    parameter int unsigned DEB_LONG_CYCLES   = 16
) (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    awvalid_i,
    input wire logic                    awready_o,
    input wire logic                    wvalid_i,
    input wire logic                    wready_o,
    input wire logic [1:0]              bresp_o,
    input wire logic                    bvalid_o,
    input wire logic                    bready_i,
    input wire logic                    arvalid_i,
    input wire logic                    arready_o,
    input wire logic [31:0]             rdata_o,
    input wire logic                    rvalid_o,
    input wire logic                    rready_i,
    input wire pin_mux_pkg::pad_t [1:0] pad_o,
    input wire logic [15:0]             role_o,
    input wire logic [1:0]              edge_event_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_rst_out;
        $fell(rst_i) |-> role_o == 16'h0 && edge_event_o == 2'h0 && !pad_o[0].oe && !pad_o[1].oe;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
    property p_pull_excl; !(pad_o[0].pull_up && pad_o[0].pull_down); endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
    // supply only moves after a register write
    property p_sup_cause; $changed(pad_o[0].supply_select) |-> $past(bvalid_o) || $past(bvalid_o, 2);
    endproperty
    a_sup_cause: assert property (p_sup_cause) else $error("supply moved without write");
    // debounce keeps qualifying edges apart
    property p_ev_gap; edge_event_o[0] |=> !edge_event_o[0] [*3]; endproperty
    a_ev_gap: assert property (p_ev_gap) else $error("event pulses too close");
    property p_b_time; awvalid_i && awready_o && wvalid_i && wready_o |-> ##2 bvalid_o; endproperty
    a_b_time: assert property (p_b_time) else $error("write answer late");
    property p_b_hold; bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_block; bvalid_o |-> !awready_o && !wready_o; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during answer");
    property p_r_time; arvalid_i && arready_o |=> rvalid_o; endproperty
    a_r_time: assert property (p_r_time) else $error("read answer late");
    property p_r_hold; rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");

    c_event: cover property (edge_event_o[0]);
    c_slverr: cover property (bvalid_o && bready_i && bresp_o == pin_mux_pkg::RESP_SLVERR);
    c_read: cover property (rvalid_o && rready_i);
endmodule : pin_mux_assertions

bind pin_mux pin_mux_assertions #(
    .DEB_NORMAL_CYCLES(DEB_NORMAL_CYCLES),
    .DEB_LONG_CYCLES(DEB_LONG_CYCLES)
) u_chk (.*);
